// [bench/ief_bus_model.sv]
// Behavioural two-wire bus master that clocks the line and pulls the data wire low.
module ief_bus_model (
   output logic sclLine,
   output logic sdaPull,
   input wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real QTR = 31.25;

   // The clock line stands high between frames, and the data line is released to its pull-up.
   initial begin
      sclLine = 1'b1;
      sdaPull = 1'b0;
   end

   task automatic start_cond;
      sdaPull = 1'b0;
      sclLine = 1'b1;
      #QTR;
      sdaPull = 1'b1;
      // The long hold lets the receiver's pin filter register the start before software reads the status.
      #(2 * QTR);
   endtask

   task automatic stop_cond;
      sclLine = 1'b0;
      #QTR;
      sdaPull = 1'b1;
      #QTR;
      sclLine = 1'b1;
      #QTR;
      sdaPull = 1'b0;
      #(2 * QTR);
   endtask

   // Data changes a quarter period after the fall and is sampled in the middle of the high phase.
   task automatic clk_bit(input logic b, output logic s);
      sclLine = 1'b0;
      #QTR;
      sdaPull = ~b;
      #QTR;
      sclLine = 1'b1;
      #QTR;
      s = sdaLine;
      #QTR;
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] seen, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], seen[i]);
      end
      clk_bit(1'b1, ack);
      sclLine = 1'b0;
      #QTR;
   endtask
endmodule

// [bench/ief_i2c_err_tb_top.sv]
// Self-checking bench for the two-wire error block, driven over the register bus and the bus model.
module ief_i2c_err_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ief_pkg::*;
   localparam int STALL = 200;
   localparam logic [31:0] SP = (32'h1 << BIT_START) | (32'h1 << BIT_STOP);
   logic core_clk, srst, avRd, avWr, avWait, irq, sdaOut, sdaOe, sclLine, sdaPull, ack;
   logic [ADDR_W-1:0] avAddr;
   logic [DATA_W-1:0] avWd, rdData, rd;
   logic [7:0] b, seen;
   int err_total, n_tests, cyc;
   wire logic sdaLine;

   // Open-drain wire: low while either party pulls, otherwise held high by the pull-up.
   assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;

   ief_i2c_err #(.STALL_CYCLES(STALL)) DUT (.core_clk(core_clk), .srst(srst), .avs_address(avAddr),
      .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWd), .avs_readdata(rdData),
      .avs_waitrequest(avWait), .irq(irq), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
   ief_bus_model mdl (.sclLine(sclLine), .sdaPull(sdaPull), .sdaLine(sdaLine));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] fbit(input int n);
      return 32'h1 << n;
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Starts on a clock edge, so calls made after the asynchronous bus model stay edge aligned.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avAddr <= a;
      avWd <= d;
      avWr <= wr;
      avRd <= ~wr;
      // A slave that never answers is caught by the cycle ceiling, which reports it as a mismatch.
      do begin
         @(posedge core_clk);
      end while (avWait !== 1'b0);
      rd = rdData;
      avRd <= 1'b0;
      avWr <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask

   task automatic rx_byte(input logic [7:0] v);
      mdl.xfer(v, seen, ack);
      chk("ack", {31'h0, ack}, 32'h0);
      rdc("rxdata", REG_RXDATA, 32'hff, {24'h0, v});
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         stop_test;
      end
   end

   initial begin
      srst = 1'b1;
      avRd = 1'b0;
      avWr = 1'b0;
      avAddr = '0;
      avWd = '0;
      cyc = 0;
      err_total = 0;
      n_tests = 0;
      void'($urandom(32'haeabc4a9));
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      rdc("ctrl", REG_CTRL, '1, CTRL_RESET);
      rdc("status", REG_STATUS, '1, STATUS_RESET);
      rdc("intmask", REG_INTMASK, '1, INTMASK_RESET);
      rdc("unmapped", 8'h20, '1, 32'h0);
      // A frame of 510 bytes at 8 MHz must leave every error flag clear.
      wr(REG_CTRL, fbit(BIT_ON));
      mdl.start_cond;
      rdc("start", REG_STATUS, SP, fbit(BIT_START));
      for (int i = 0; i < 510; i++) begin
         rx_byte(8'($urandom));
      end
      rdc("long", REG_STATUS, STATUS_W1C, 32'h0);
      mdl.stop_cond;
      rdc("stop", REG_STATUS, SP, fbit(BIT_STOP));
      mdl.start_cond;
      b = 8'($urandom);
      mdl.xfer(b, seen, ack);
      mdl.xfer(~b, seen, ack);
      rdc("ovf", REG_STATUS, fbit(BIT_OVF), fbit(BIT_OVF));
      mdl.xfer(8'h5a, seen, ack);
      rdc("ovf held", REG_STATUS, fbit(BIT_OVF), fbit(BIT_OVF));
      rdc("kept", REG_RXDATA, 32'hff, {24'h0, b});
      wr(REG_STATUS, fbit(BIT_OVF));
      rdc("ovf clr", REG_STATUS, fbit(BIT_OVF), 32'h0);
      rx_byte(8'($urandom));
      mdl.stop_cond;
      // An armed byte in slave mode must not turn pulled bits into a collision.
      wr(REG_TXDATA, 32'h0000_00ff);
      mdl.start_cond;
      rx_byte(8'h00);
      rdc("slave coll", REG_STATUS, fbit(BIT_COLL), 32'h0);
      mdl.stop_cond;
      b = 8'($urandom) | 8'h80;
      wr(REG_CTRL, fbit(BIT_ON) | fbit(BIT_MASTER));
      wr(REG_TXDATA, {24'h0, b});
      mdl.start_cond;
      mdl.xfer(8'hff, seen, ack);
      chk("tx byte", {24'h0, seen}, {24'h0, b});
      rdc("no coll", REG_STATUS, fbit(BIT_COLL), 32'h0);
      mdl.stop_cond;
      wr(REG_TXDATA, {24'h0, b});
      mdl.start_cond;
      mdl.xfer(8'h00, seen, ack);
      rdc("coll", REG_STATUS, fbit(BIT_COLL), fbit(BIT_COLL));
      chk("irq set", {31'h0, irq}, 32'h1);
      wr(REG_INTMASK, 32'h0);
      repeat (2) @(posedge core_clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(REG_INTMASK, INTMASK_RESET);
      repeat (2) @(posedge core_clk);
      chk("irq unmasked", {31'h0, irq}, 32'h1);
      mdl.stop_cond;
      // Software checks the stop flag first, so the collision is cleared on an idle bus only.
      rdc("idle", REG_STATUS, SP, fbit(BIT_STOP));
      rdc("coll held", REG_STATUS, fbit(BIT_COLL), fbit(BIT_COLL));
      wr(REG_STATUS, fbit(BIT_COLL));
      rdc("coll clr", REG_STATUS, fbit(BIT_COLL), 32'h0);
      rdc("intstat", REG_INTSTAT, fbit(BIT_COLL), fbit(BIT_COLL));
      repeat (2) @(posedge core_clk);
      chk("irq clr", {31'h0, irq}, 32'h0);
      // The clock stops inside a frame; the watchdog flag then leads software to disable.
      wr(REG_CTRL, fbit(BIT_ON));
      mdl.start_cond;
      repeat (STALL + 50) @(posedge core_clk);
      rdc("stall", REG_STATUS, fbit(BIT_STALL), fbit(BIT_STALL));
      wr(REG_CTRL, 32'h0);
      rdc("cleared", REG_STATUS, '1, 32'h0);
      mdl.stop_cond;
      wr(REG_CTRL, fbit(BIT_ON));
      mdl.start_cond;
      rx_byte(8'($urandom));
      rdc("resumed", REG_STATUS, STATUS_W1C, 32'h0);
      mdl.stop_cond;
      stop_test;
   end
endmodule

// [include/ief_pkg.sv]
// Package with register map, status fields, link states and timing for the two-wire error block.
package ief_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 3;

   // Byte addresses of the word registers.
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h08;
   localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_INTSTAT = 8'h10;
   localparam logic [ADDR_W-1:0] REG_INTMASK = 8'h14;

   // Control register fields.
   localparam int BIT_MASTER = 0;
   localparam int BIT_ON = 15;
   localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_8001;
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields; the event and mask registers share this layout.
   localparam int BIT_RXFULL = 1;
   localparam int BIT_START = 3;
   localparam int BIT_STOP = 4;
   localparam int BIT_STALL = 6;
   localparam int BIT_COLL = 10;
   localparam int BIT_OVF = 20;
   localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] STATUS_W1C = 32'h0010_0440;
   localparam logic [DATA_W-1:0] INTSTAT_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] INTMASK_RESET = 32'h0000_0400;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;

   // Timing: core clock and the bus-stall watchdog.
   localparam int CLK_HZ = 100_000_000;
   localparam int STALL_TIME_US = 1000;
   localparam int STALL_CYCLES_DEF = (CLK_HZ / 1_000_000) * STALL_TIME_US;
   localparam int DISABLE_CLR_INSTR = 4;

   typedef enum logic [2:0] {
      LNK_IDLE = 3'b001,
      LNK_BYTE = 3'b010,
      LNK_ACK = 3'b100
   } ief_link_t;
endpackage

// [rtl/ief_bus_cond.sv]
// Edge and start/stop condition detector on the synchronised clock and data lines.
module ief_bus_cond (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sclLvl,
   input wire logic sdaLvl,
   output logic sclRise,
   output logic sclFall,
   output logic startDet,
   output logic stopDet
);
   import ief_pkg::*;

   logic sclPrev, sdaPrev;
   logic next_sclPrev, next_sdaPrev;

   always_comb begin
      next_sclPrev = sclLvl;
      next_sdaPrev = sdaLvl;
      sclRise = sclLvl && !sclPrev;
      sclFall = !sclLvl && sclPrev;
      // Data moving while the clock stays high marks a frame boundary.
      startDet = sclLvl && sclPrev && sdaPrev && !sdaLvl;
      stopDet = sclLvl && sclPrev && !sdaPrev && sdaLvl;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= next_sclPrev;
         sdaPrev <= next_sdaPrev;
      end
   end
endmodule

// [rtl/ief_i2c_err.sv]
// Two-wire controller error flags, byte link and recovery with an Avalon-MM register slave.
// Notes on behaviour
// - Collision flag, status bit 10, is set on a detected collision in master mode only.
// - Overflow flag, status bit 20, is set when a byte arrives while one waits.
// - Start is shown in status bit 3 and stop in status bit 4.
// - Software may clear the overflow flag; reception and transmission then carry on.
// - Clearing enable, control bit 15, clears the whole status register within 4 cycles.
// - Setting enable again after the clear resumes normal operation.
// - A set collision flag raises the interrupt.
// - Error flags never assert falsely at fast rates or in long transfers.
// - A stalled transfer always leaves an error indication that software can see.
module ief_i2c_err #(
   parameter int STALL_CYCLES = ief_pkg::STALL_CYCLES_DEF
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [ief_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ief_pkg::DATA_W-1:0] avs_writedata,
   output logic [ief_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);
   import ief_pkg::*;

   localparam int STALL_W = $clog2(STALL_CYCLES + 1);
   localparam logic [STALL_W-1:0] STALL_LAST = STALL_W'(STALL_CYCLES - 1);
   localparam logic [STALL_W-1:0] STALL_ZERO = '0;
   localparam logic [STALL_W-1:0] STALL_ONE = STALL_W'(1);

   logic sclLvl, sdaLvl, sclRise, sclFall, startDet, stopDet;
   logic [DATA_W-1:0] ctrl, status, intStat, intMask, next_ctrl, next_status, next_intStat, next_intMask;
   logic [DATA_W-1:0] next_readdata, evVec;
   logic ack, next_ack, next_irq;
   logic [BYTE_W-1:0] rxData, txData, shiftReg, next_rxData, next_txData, next_shiftReg, rxByte;
   logic txArmed, txBusy, driveLow, next_txArmed, next_txBusy, next_driveLow;
   logic [CNT_W-1:0] bitCnt, next_bitCnt;
   logic [STALL_W-1:0] stallCnt, next_stallCnt;
   ief_link_t state, next_state;
   logic enable, master, accRd, accWr, rxTaken, txTaken;
   logic evColl, evOvf, evByte, evStall;

   ief_pin_sync #(.W(2)) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .raw({sclIn, sdaIn}),
      .lvl({sclLvl, sdaLvl})
   );

   ief_bus_cond u_cond (
      .core_clk(core_clk),
      .srst(srst),
      .sclLvl(sclLvl),
      .sdaLvl(sdaLvl),
      .sclRise(sclRise),
      .sclFall(sclFall),
      .startDet(startDet),
      .stopDet(stopDet)
   );

   assign enable = ctrl[BIT_ON];
   assign master = ctrl[BIT_MASTER];
   assign accRd = avs_read && ack;
   assign accWr = avs_write && ack;
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign rxTaken = accRd && (avs_address == REG_RXDATA);
   assign txTaken = enable && startDet && !stopDet && txArmed && master;
   assign rxByte = {shiftReg[BYTE_W-2:0], sdaLvl};
   // The line is open drain: only a low level is ever driven.
   assign sdaOut = 1'b0;
   assign sdaOe = driveLow;

   // Link state: bit shifting, acknowledge, collision check and stall watchdog.
   always_comb begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_shiftReg = shiftReg;
      next_txBusy = txBusy;
      next_driveLow = driveLow;
      next_stallCnt = stallCnt;
      evColl = 1'b0;
      evByte = 1'b0;
      evStall = 1'b0;
      if (!enable) begin
         next_state = LNK_IDLE;
         next_bitCnt = CNT_ZERO;
         next_txBusy = 1'b0;
         next_driveLow = 1'b0;
         next_stallCnt = STALL_ZERO;
      end else if (stopDet) begin
         next_state = LNK_IDLE;
         next_txBusy = 1'b0;
         next_driveLow = 1'b0;
      end else if (startDet) begin
         next_state = LNK_BYTE;
         next_bitCnt = CNT_ZERO;
         next_txBusy = txTaken;
         next_driveLow = 1'b0;
      end else begin
         case (state)
            LNK_IDLE: begin
               next_bitCnt = CNT_ZERO;
            end
            LNK_BYTE: begin
               if (sclRise) begin
                  next_shiftReg = rxByte;
                  next_bitCnt = bitCnt + CNT_ONE;
                  // Released line read back low while sending: another master won.
                  if (txBusy && master && !driveLow && !sdaLvl) begin
                     evColl = 1'b1;
                     next_state = LNK_IDLE;
                     next_txBusy = 1'b0;
                  end else if (bitCnt == LAST_BIT) begin
                     next_state = LNK_ACK;
                     evByte = !txBusy;
                  end
               end else if (sclFall) begin
                  next_driveLow = txBusy && !txData[LAST_BIT - bitCnt];
               end
            end
            LNK_ACK: begin
               if (sclRise) begin
                  next_state = LNK_BYTE;
                  next_bitCnt = CNT_ZERO;
                  next_txBusy = 1'b0;
               end else if (sclFall) begin
                  // As receiver pull the acknowledge low; as sender leave it to the far end.
                  next_driveLow = !txBusy;
               end
            end
            default: begin
               next_state = LNK_IDLE;
            end
         endcase
         // A frame with no clock edge for too long is dropped and flagged, never left hanging.
         if (state == LNK_IDLE || sclRise || sclFall) begin
            next_stallCnt = STALL_ZERO;
         end else if (stallCnt == STALL_LAST) begin
            evStall = 1'b1;
            next_stallCnt = STALL_ZERO;
            next_state = LNK_IDLE;
            next_txBusy = 1'b0;
            next_driveLow = 1'b0;
         end else begin
            next_stallCnt = stallCnt + STALL_ONE;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= LNK_IDLE;
         bitCnt <= CNT_ZERO;
         shiftReg <= BYTE_RESET;
         txBusy <= 1'b0;
         driveLow <= 1'b0;
         stallCnt <= STALL_ZERO;
      end else begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         shiftReg <= next_shiftReg;
         txBusy <= next_txBusy;
         driveLow <= next_driveLow;
         stallCnt <= next_stallCnt;
      end
   end

   // Registers, flags and bus slave.
   always_comb begin
      next_ctrl = ctrl;
      next_status = status;
      next_intMask = intMask;
      next_rxData = rxData;
      next_txData = txData;
      next_txArmed = txArmed && !txTaken;
      next_ack = (avs_read || avs_write) && !ack;
      next_readdata = avs_readdata;
      evOvf = evByte && status[BIT_RXFULL] && !rxTaken;
      evVec = READ_ZERO;
      evVec[BIT_COLL] = evColl;
      evVec[BIT_OVF] = evOvf;
      evVec[BIT_START] = enable && startDet;
      evVec[BIT_STOP] = enable && stopDet;
      evVec[BIT_RXFULL] = evByte;
      evVec[BIT_STALL] = evStall;
      if (avs_read && !ack) begin
         case (avs_address)
            REG_CTRL: next_readdata = ctrl;
            REG_STATUS: next_readdata = status;
            REG_RXDATA: next_readdata = {{(DATA_W - BYTE_W){1'b0}}, rxData};
            REG_TXDATA: next_readdata = {{(DATA_W - BYTE_W){1'b0}}, txData};
            REG_INTSTAT: next_readdata = intStat;
            REG_INTMASK: next_readdata = intMask;
            default: next_readdata = READ_ZERO;
         endcase
      end
      if (accWr) begin
         case (avs_address)
            REG_CTRL: next_ctrl = avs_writedata & CTRL_MASK;
            REG_STATUS: next_status = status & ~(avs_writedata & STATUS_W1C);
            REG_TXDATA: begin
               next_txData = avs_writedata[BYTE_W-1:0];
               next_txArmed = 1'b1;
            end
            REG_INTMASK: next_intMask = avs_writedata;
            default: next_intMask = intMask;
         endcase
      end
      // Only bits that the read really returned are cleared, so a same-cycle event survives.
      next_intStat = (accRd && avs_address == REG_INTSTAT) ? (intStat & ~avs_readdata) : intStat;
      next_intStat = next_intStat | evVec;
      if (rxTaken) begin
         next_status[BIT_RXFULL] = 1'b0;
      end
      if (evByte && !evOvf) begin
         next_rxData = rxByte;
         next_status[BIT_RXFULL] = 1'b1;
      end
      // Hardware sets after the software clear, so a set in the same cycle wins.
      if (evColl) begin
         next_status[BIT_COLL] = 1'b1;
      end
      if (evOvf) begin
         next_status[BIT_OVF] = 1'b1;
      end
      if (evStall) begin
         next_status[BIT_STALL] = 1'b1;
      end
      if (enable && startDet) begin
         next_status[BIT_START] = 1'b1;
         next_status[BIT_STOP] = 1'b0;
      end else if (enable && stopDet) begin
         next_status[BIT_STOP] = 1'b1;
         next_status[BIT_START] = 1'b0;
      end
      // A disabled module holds its whole status word clear until enabled again.
      if (!enable) begin
         next_status = STATUS_RESET;
         next_txArmed = 1'b0;
      end
      next_irq = |(next_intStat & next_intMask);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl <= CTRL_RESET;
         status <= STATUS_RESET;
         intStat <= INTSTAT_RESET;
         intMask <= INTMASK_RESET;
         rxData <= BYTE_RESET;
         txData <= BYTE_RESET;
         txArmed <= 1'b0;
         ack <= 1'b0;
         avs_readdata <= READ_ZERO;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         status <= next_status;
         intStat <= next_intStat;
         intMask <= next_intMask;
         rxData <= next_rxData;
         txData <= next_txData;
         txArmed <= next_txArmed;
         ack <= next_ack;
         avs_readdata <= next_readdata;
         irq <= next_irq;
      end
   end

   AST_COLL_MASTER: assert property (@(posedge core_clk) disable iff (srst)
      $rose(status[BIT_COLL]) |-> $past(master) && $past(txBusy))
      else $error("collision flag set outside a master transmission");

   AST_OVF_CAUSE: assert property (@(posedge core_clk) disable iff (srst)
      $rose(status[BIT_OVF]) |-> $past(status[BIT_RXFULL]) && $past(evByte))
      else $error("overflow flag set without a waiting byte");

   AST_START_STOP: assert property (@(posedge core_clk) disable iff (srst)
      (enable && startDet && !stopDet) |=> status[BIT_START] && !status[BIT_STOP])
      else $error("start condition not reported");

   AST_OVF_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
      (accWr && avs_address == REG_STATUS && avs_writedata[BIT_OVF] && !evOvf) |=> !status[BIT_OVF])
      else $error("overflow flag did not clear on software write");

   AST_DISABLE_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
      $fell(enable) |-> ##[0:3] (status == STATUS_RESET))
      else $error("status not cleared after disable");

   AST_REENABLE: assert property (@(posedge core_clk) disable iff (srst)
      $rose(enable) |-> (status == STATUS_RESET) && state == LNK_IDLE)
      else $error("module did not restart from a clean state");

   AST_IRQ_COLL: assert property (@(posedge core_clk) disable iff (srst)
      ($rose(status[BIT_COLL]) && intMask[BIT_COLL]) |-> irq)
      else $error("collision did not raise the interrupt");

   AST_NO_FALSE_COLL: assert property (@(posedge core_clk) disable iff (srst)
      $rose(status[BIT_COLL]) |-> $past(sclRise) && !$past(sdaLvl) && !$past(driveLow))
      else $error("collision flagged without a lost bit");

   AST_STALL_FLAG: assert property (@(posedge core_clk) disable iff (srst)
      (enable && state != LNK_IDLE && !sclRise && !sclFall && !startDet && !stopDet && stallCnt == STALL_LAST)
      |=> status[BIT_STALL] && state == LNK_IDLE)
      else $error("stalled frame left without an error flag");

   AST_STICKY: assert property (@(posedge core_clk) disable iff (srst)
      (status[BIT_COLL] && enable && !(accWr && avs_address == REG_STATUS && avs_writedata[BIT_COLL]))
      |=> status[BIT_COLL])
      else $error("collision flag cleared by hardware");
endmodule

// [rtl/ief_pin_sync.sv]
// Three-stage synchroniser with agreement filter for the bus pins.
module ief_pin_sync #(
   parameter int W = 2
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] lvl
);
   import ief_pkg::*;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : gen_bit
         logic s1, s2, s3, q;
         logic next_q;
         // The output moves only when the last two stages agree, so one glitchy sample is not counted.
         always_comb begin
            next_q = (s2 == s3) ? s3 : q;
         end
         always_ff @(posedge core_clk) begin
            if (srst) begin
               s1 <= 1'b1;
               s2 <= 1'b1;
               s3 <= 1'b1;
               q <= 1'b1;
            end else begin
               s1 <= raw[g];
               s2 <= s1;
               s3 <= s2;
               q <= next_q;
            end
         end
         assign lvl[g] = q;
      end
   endgenerate
endmodule
